// >>> design/rf_channel_and_if_setting_regs.sv
// Operation
// - Carrier held as 30-bit value, 1 Hz steps
// - Word spans 100 MHz to 1000 MHz
// - Carrier resets to 36FC3BA0H, 922.5 MHz
// - Control bit 0 picks 550/750 kHz IF
// - Control bit 1 enables frequency shift function
// - Control bit 2 applies offset, else none
// - Control bit 3 picks offset register 0/1
// - Control byte resets to 00H
// - Offset zero is signed, 1 Hz steps
// - Offset zero resets to 000000H
//
// Our own choice: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none

module rf_channel_and_if_setting_regs
  import rf_channel_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [OFFSET_W-1:0] intermediate_offset_one_i,
  output logic [CARRIER_W-1:0] carrier_hz_value_o,
  output logic carrier_update_o,
  output logic carrier_in_band_o,
  output logic intermediate_band_select_o,
  output logic shift_apply_enable_o,
  output logic intermediate_offset_enable_o,
  output logic intermediate_offset_choice_o,
  output logic [OFFSET_W-1:0] intermediate_offset_zero_o,
  output logic signed [IF_W-1:0] applied_offset_o,
  output logic signed [IF_W-1:0] intermediate_hz_o
);

  // Replace the byte lanes picked by sel, keep the others
  function automatic logic [DAT_W-1:0] merge_lanes(
    input logic [DAT_W-1:0] old_word,
    input logic [DAT_W-1:0] new_word,
    input logic [SEL_W-1:0] sel
  );
    logic [DAT_W-1:0] res;
    res = old_word;
    for (int i = 0; i < SEL_W; i++)
    begin
      if (sel[i])
      begin
        res[8*i +: 8] = new_word[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Word address compare, low two address bits ignored
  function automatic logic word_hit(
    input logic [ADR_W-1:0] adr,
    input logic [ADR_W-1:0] ofs
  );
    return adr[ADR_W-1:2] == ofs[ADR_W-1:2];
  endfunction

  // Offset word widened with its sign
  function automatic logic signed [IF_W-1:0] sext_offset(
    input logic [OFFSET_W-1:0] ofs
  );
    return {{(IF_W-OFFSET_W){ofs[OFFSET_W-1]}}, ofs};
  endfunction

  // Bus slave state
  logic ack_q, ack_d;                                // Single-cycle acknowledge
  logic [DAT_W-1:0] rdat_q, rdat_d;                  // Registered read data

  // Register file state
  logic [CARRIER_W-1:0] carrier_q, carrier_d;        // Active carrier word
  logic [DAT_W-1:0] stage_q, stage_d;                // Bytes collected so far
  logic pending_q, pending_d;                        // Lower bytes written, top not yet
  logic update_q, update_d;                          // One-cycle commit pulse
  logic in_band_q, in_band_d;                        // Carrier inside software band
  if_cfg_t cfg_q, cfg_d;                             // Intermediate band control
  logic [OFFSET_W-1:0] ofs0_q, ofs0_d;               // Offset register zero

  // Derived frequency state
  logic signed [IF_W-1:0] applied_q, applied_d;      // Offset in use
  logic signed [IF_W-1:0] if_hz_q, if_hz_d;          // Resulting IF in Hz

  // Decoded request, only while no ack is out
  logic req;
  logic wr;
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;

  // Next values for bus answer and registers
  always_comb
  begin
    logic [DAT_W-1:0] merged;
    merged = '0;
    ack_d = req;
    rdat_d = rdat_q;
    carrier_d = carrier_q;
    stage_d = stage_q;
    pending_d = pending_q;
    update_d = 1'b0;
    cfg_d = cfg_q;
    ofs0_d = ofs0_q;
    // Writes
    if (wr && word_hit(wb_adr_i, CARRIER_SETTING_OFS))
    begin
      // Lanes gather in the stage so a half-written word stays invisible
      merged = merge_lanes(stage_q, wb_dat_i, wb_sel_i);
      stage_d = merged;
      if (wb_sel_i[CARRIER_TOP_LANE])
      begin
        carrier_d = merged[CARRIER_W-1:0];
        pending_d = 1'b0;
        update_d = 1'b1;
      end
      else
      begin
        pending_d = 1'b1;
      end
    end
    else if (wr && word_hit(wb_adr_i, INTERMEDIATE_BAND_CONFIG_OFS))
    begin
      merged = merge_lanes({{(DAT_W-IF_CFG_W){1'b0}}, cfg_q}, wb_dat_i, wb_sel_i);
      cfg_d = if_cfg_t'(merged[IF_CFG_W-1:0]);
    end
    else if (wr && word_hit(wb_adr_i, INTERMEDIATE_OFFSET_ZERO_OFS))
    begin
      merged = merge_lanes({{(DAT_W-OFFSET_W){1'b0}}, ofs0_q}, wb_dat_i, wb_sel_i);
      ofs0_d = merged[OFFSET_W-1:0];
    end
    // Reads; unmapped addresses answer zero
    if (req && !wb_we_i)
    begin
      if (word_hit(wb_adr_i, CARRIER_SETTING_OFS))
      begin
        rdat_d = {{(DAT_W-CARRIER_W){1'b0}}, carrier_q};
      end
      else if (word_hit(wb_adr_i, INTERMEDIATE_BAND_CONFIG_OFS))
      begin
        rdat_d = {{(DAT_W-IF_CFG_W){1'b0}}, cfg_q};
      end
      else if (word_hit(wb_adr_i, INTERMEDIATE_OFFSET_ZERO_OFS))
      begin
        rdat_d = {{(DAT_W-OFFSET_W){1'b0}}, ofs0_q};
      end
      else if (word_hit(wb_adr_i, CHANNEL_STATUS_OFS))
      begin
        rdat_d = '0;
        rdat_d[STAT_IN_BAND_BIT] = in_band_q;
        rdat_d[STAT_PENDING_BIT] = pending_q;
      end
      else
      begin
        rdat_d = '0;
      end
    end
    // Band check only flags; an out-of-band word is still used
    in_band_d = (carrier_d >= CARRIER_BAND_MIN) && (carrier_d <= CARRIER_BAND_MAX);
  end

  // Register bus answer and register file
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= '0;
      carrier_q <= CARRIER_RST;
      stage_q <= {{(DAT_W-CARRIER_W){1'b0}}, CARRIER_RST};
      pending_q <= 1'b0;
      update_q <= 1'b0;
      in_band_q <= 1'b1;
      cfg_q <= if_cfg_t'(IF_CFG_RST);
      ofs0_q <= OFFSET_ZERO_RST;
    end
    else if (ce_i)
    begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      carrier_q <= carrier_d;
      stage_q <= stage_d;
      pending_q <= pending_d;
      update_q <= update_d;
      in_band_q <= in_band_d;
      cfg_q <= cfg_d;
      ofs0_q <= ofs0_d;
    end
  end

  // Derived IF, computed from the next register values so it moves with them
  always_comb
  begin
    if (!cfg_d.offset_enable)
    begin
      applied_d = '0;
    end
    else if (cfg_d.offset_choice)
    begin
      applied_d = sext_offset(intermediate_offset_one_i);
    end
    else
    begin
      applied_d = sext_offset(ofs0_d);
    end
    // Sum cannot wrap inside the software offset limits
    if_hz_d = (cfg_d.band_select ? IF_HIGH_HZ : IF_LOW_HZ) + applied_d;
  end

  // Derived IF registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      applied_q <= '0;
      if_hz_q <= IF_LOW_HZ;
    end
    else if (ce_i)
    begin
      applied_q <= applied_d;
      if_hz_q <= if_hz_d;
    end
  end

  // Outputs, all from flip-flops
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign carrier_hz_value_o = carrier_q;
  assign carrier_update_o = update_q;
  assign carrier_in_band_o = in_band_q;
  assign intermediate_band_select_o = cfg_q.band_select;
  assign shift_apply_enable_o = cfg_q.shift_enable;
  assign intermediate_offset_enable_o = cfg_q.offset_enable;
  assign intermediate_offset_choice_o = cfg_q.offset_choice;
  assign intermediate_offset_zero_o = ofs0_q;
  assign applied_offset_o = applied_q;
  assign intermediate_hz_o = if_hz_q;

  // Reset value of the carrier word
  property p_carrier_reset;
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> carrier_hz_value_o == CARRIER_RST;
  endproperty
  a_carrier_reset: assert property (p_carrier_reset) else $error("carrier word not at reset value");

  // Reset value of the control byte
  property p_cfg_reset;
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> {intermediate_offset_choice_o, intermediate_offset_enable_o,
      shift_apply_enable_o, intermediate_band_select_o} == IF_CFG_RST && intermediate_hz_o == IF_LOW_HZ;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("control byte not at reset value");

  // Reset value of offset zero
  property p_offset_reset;
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> intermediate_offset_zero_o == OFFSET_ZERO_RST;
  endproperty
  a_offset_reset: assert property (p_offset_reset) else $error("offset zero not at reset value");

  // Partial carrier write leaves the word alone
  property p_partial_hold;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && wr && word_hit(wb_adr_i, CARRIER_SETTING_OFS) && !wb_sel_i[CARRIER_TOP_LANE]
      |=> $stable(carrier_hz_value_o) && !carrier_update_o;
  endproperty
  a_partial_hold: assert property (p_partial_hold) else $error("carrier changed before top byte");

  // Full word write lands as written, low 30 bits
  property p_full_write;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && wr && word_hit(wb_adr_i, CARRIER_SETTING_OFS) && wb_sel_i == 4'hF
      |=> carrier_hz_value_o == CARRIER_W'($past(wb_dat_i)) && carrier_update_o;
  endproperty
  a_full_write: assert property (p_full_write) else $error("carrier word not written");

  // Carrier reads show zero in the top two bits
  property p_carrier_top_zero;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_we_i && word_hit(wb_adr_i, CARRIER_SETTING_OFS)
      |-> wb_dat_o[DAT_W-1:CARRIER_W] == 2'h0 && wb_dat_o[CARRIER_W-1:0] == carrier_hz_value_o;
  endproperty
  a_carrier_top_zero: assert property (p_carrier_top_zero) else $error("carrier read wrong");

  // Control reads show zero in the upper bits
  property p_cfg_top_zero;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_we_i && word_hit(wb_adr_i, INTERMEDIATE_BAND_CONFIG_OFS)
      |-> wb_dat_o[DAT_W-1:IF_CFG_W] == 28'h0000000;
  endproperty
  a_cfg_top_zero: assert property (p_cfg_top_zero) else $error("control read upper bits not zero");

  // Offset off means base IF exactly
  property p_no_offset;
    @(posedge clk_i) disable iff (rst_i)
    !intermediate_offset_enable_o |-> applied_offset_o == '0 &&
      intermediate_hz_o == (intermediate_band_select_o ? IF_HIGH_HZ : IF_LOW_HZ);
  endproperty
  a_no_offset: assert property (p_no_offset) else $error("offset applied while disabled");

  // Offset zero applied as a signed value
  property p_offset_zero_used;
    @(posedge clk_i) disable iff (rst_i)
    intermediate_offset_enable_o && !intermediate_offset_choice_o
      |-> applied_offset_o == sext_offset(intermediate_offset_zero_o);
  endproperty
  a_offset_zero_used: assert property (p_offset_zero_used) else $error("offset zero not applied");

  // Offset one taken when chosen
  property p_offset_one_used;
    @(posedge clk_i) disable iff (rst_i)
    $past(ce_i) && intermediate_offset_enable_o && intermediate_offset_choice_o
      |-> applied_offset_o == sext_offset($past(intermediate_offset_one_i));
  endproperty
  a_offset_one_used: assert property (p_offset_one_used) else $error("offset one not applied");

  // Offset in use adds onto the chosen base IF
  property p_offset_sum;
    @(posedge clk_i) disable iff (rst_i)
    intermediate_offset_enable_o
      |-> intermediate_hz_o == (intermediate_band_select_o ? IF_HIGH_HZ : IF_LOW_HZ) + applied_offset_o;
  endproperty
  a_offset_sum: assert property (p_offset_sum) else $error("intermediate frequency sum wrong");

  // Without a top-lane carrier write the active word stays put
  property p_carrier_hold;
    @(posedge clk_i) disable iff (rst_i)
    !(ce_i && wr && word_hit(wb_adr_i, CARRIER_SETTING_OFS) && wb_sel_i[CARRIER_TOP_LANE])
      |=> $stable(carrier_hz_value_o);
  endproperty
  a_carrier_hold: assert property (p_carrier_hold) else $error("carrier changed without a commit");

  // Ack lasts one cycle
  property p_ack_single;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack held too long");

endmodule

`default_nettype wire

// >>> design/rf_channel_pkg.sv
package rf_channel_pkg;

  // Bus geometry
  localparam int ADR_W = 8;                          // Byte address width
  localparam int DAT_W = 32;                         // Data width
  localparam int SEL_W = 4;                          // Byte lanes

  // Register byte addresses
  localparam logic [ADR_W-1:0] CARRIER_SETTING_OFS = 8'hA8;
  localparam logic [ADR_W-1:0] INTERMEDIATE_BAND_CONFIG_OFS = 8'hAC;
  localparam logic [ADR_W-1:0] INTERMEDIATE_OFFSET_ZERO_OFS = 8'hB4;
  localparam logic [ADR_W-1:0] CHANNEL_STATUS_OFS = 8'hB8;

  // Carrier word
  localparam int CARRIER_W = 30;                     // 1 Hz per step
  localparam logic [CARRIER_W-1:0] CARRIER_RST = 30'h36FC3BA0;
  localparam logic [CARRIER_W-1:0] CARRIER_BAND_MIN = 30'h337055C0;
  localparam logic [CARRIER_W-1:0] CARRIER_BAND_MAX = 30'h37502800;
  localparam int CARRIER_TOP_LANE = 3;               // Lane that commits the word

  // Intermediate band control byte
  localparam int IF_CFG_W = 4;
  localparam int BAND_SELECT_BIT = 0;
  localparam int SHIFT_ENABLE_BIT = 1;
  localparam int OFFSET_ENABLE_BIT = 2;
  localparam int OFFSET_CHOICE_BIT = 3;
  localparam logic [IF_CFG_W-1:0] IF_CFG_RST = 4'h0;

  // Offset word, two's complement, 1 Hz per step
  localparam int OFFSET_W = 24;
  localparam logic [OFFSET_W-1:0] OFFSET_ZERO_RST = 24'h000000;

  // Intermediate frequencies in Hz
  localparam int IF_W = 25;
  localparam logic signed [IF_W-1:0] IF_LOW_HZ = 25'sd550000;
  localparam logic signed [IF_W-1:0] IF_HIGH_HZ = 25'sd750000;

  // Status bit positions
  localparam int STAT_IN_BAND_BIT = 0;
  localparam int STAT_PENDING_BIT = 1;

  // Control byte as stored
  typedef struct packed {
    logic offset_choice;                             // Bit 3
    logic offset_enable;                             // Bit 2
    logic shift_enable;                              // Bit 1
    logic band_select;                               // Bit 0
  } if_cfg_t;

endpackage

// >>> verif/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb import rf_channel_pkg::*;;
  // Stimulus and observed ports
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = 8'h00;
  logic [SEL_W-1:0] wb_sel_i = 4'h0;
  logic [DAT_W-1:0] wb_dat_i = 32'h00000000;
  logic [DAT_W-1:0] wb_dat_o;
  logic wb_ack_o;
  logic [OFFSET_W-1:0] intermediate_offset_one_i = 24'h000000;
  logic [CARRIER_W-1:0] carrier_hz_value_o;
  logic carrier_update_o;
  logic carrier_in_band_o;
  logic band_o;
  logic shift_o;
  logic ofs_en_o;
  logic choice_o;
  logic [OFFSET_W-1:0] ofs_zero_o;
  logic signed [IF_W-1:0] applied_offset_o;
  logic signed [IF_W-1:0] intermediate_hz_o;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] rd;

  // Free-running 100 MHz clock
  always #5 clk_i = ~clk_i;

  rf_channel_and_if_setting_regs rf_channel_and_if_setting_regs_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .intermediate_offset_one_i(intermediate_offset_one_i),
    .carrier_hz_value_o(carrier_hz_value_o), .carrier_update_o(carrier_update_o),
    .carrier_in_band_o(carrier_in_band_o), .intermediate_band_select_o(band_o),
    .shift_apply_enable_o(shift_o), .intermediate_offset_enable_o(ofs_en_o),
    .intermediate_offset_choice_o(choice_o), .intermediate_offset_zero_o(ofs_zero_o),
    .applied_offset_o(applied_offset_o), .intermediate_hz_o(intermediate_hz_o)
  );

  // Verdict and end of run
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Single comparison point
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Classic cycle; hold>0 freezes the block with ce_i low meanwhile
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                          input logic [31:0] dat, input int hold);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    if (hold > 0)
    begin
      ce_i <= 1'b0;
      repeat (hold) @(posedge clk_i);
      check({31'h0, wb_ack_o}, 32'h0);
      ce_i <= 1'b1;
    end
    @(posedge clk_i);
    // Only the bench timeout ends this wait
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    wb_cycle(1'b1, adr, sel, dat, 0);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb_cycle(1'b0, adr, 4'hF, 32'h0, 0);
    check(rd, exp);
  endtask

  // Defaults after reset
  task automatic t_reset();
    check({2'b00, carrier_hz_value_o}, 32'h36FC3BA0);
    rd_chk(8'hA8, 32'h36FC3BA0);
    rd_chk(8'hAC, 32'h00000000);
    rd_chk(8'hB4, 32'h00000000);
    check({7'h00, intermediate_hz_o}, 32'h00086470);
    $display("test reset done");
  endtask

  // Lane-by-lane carrier write; top lane commits
  task automatic t_carrier_bytes();
    wr(8'hA8, 4'h1, 32'h000000C0);
    wr(8'hA8, 4'h2, 32'h00005500);
    wr(8'hA8, 4'h4, 32'h00700000);
    check({31'h0, carrier_update_o}, 32'h0);
    check({2'b00, carrier_hz_value_o}, 32'h36FC3BA0);
    rd_chk(8'hA8, 32'h36FC3BA0);
    rd_chk(8'hB8, 32'h00000003);
    // Top bits set on purpose: must be dropped
    wr(8'hA8, 4'h8, 32'hF3000000);
    check({31'h0, carrier_update_o}, 32'h1);
    check({2'b00, carrier_hz_value_o}, 32'h337055C0);
    rd_chk(8'hA8, 32'h337055C0);
    rd_chk(8'hB8, 32'h00000001);
    $display("test carrier bytes done");
  endtask

  // Band edges of the carrier word
  task automatic t_carrier_range();
    logic [31:0] vals [4] = '{32'h37502800, 32'h37502801, 32'h337055BF, 32'h05F5E100};
    logic [31:0] inb [4] = '{32'h1, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 4; i++)
    begin
      wr(8'hA8, 4'hF, vals[i]);
      check({31'h0, carrier_update_o}, 32'h1);
      @(posedge clk_i);
      check({2'b00, carrier_hz_value_o}, vals[i]);
      check({31'h0, carrier_in_band_o}, inb[i]);
    end
    // Stalled read with the clock enable low
    wb_cycle(1'b0, 8'hA8, 4'hF, 32'h0, 3);
    check(rd, 32'h05F5E100);
    $display("test carrier range done");
  endtask

  // Each control bit alone, upper nibble dropped
  task automatic t_ctrl_bits();
    for (int i = 0; i < 4; i++)
    begin
      wr(8'hAC, 4'hF, 32'hFFFFFFF0 | (32'h1 << i));
      check({28'h0, choice_o, ofs_en_o, shift_o, band_o}, 32'h1 << i);
      rd_chk(8'hAC, 32'h1 << i);
    end
    $display("test control bits done");
  endtask

  // Offset sources, sign and enable
  task automatic t_offset();
    wr(8'hAC, 4'hF, 32'h00000004);
    wr(8'hB4, 4'hF, 32'hAAFFFC18);
    rd_chk(8'hB4, 32'h00FFFC18);
    check({8'h00, ofs_zero_o}, 32'h00FFFC18);
    check({7'h00, applied_offset_o}, 32'h01FFFC18);
    check({7'h00, intermediate_hz_o}, 32'h00086088);
    wr(8'hAC, 4'hF, 32'h00000005);
    check({7'h00, intermediate_hz_o}, 32'h000B6DC8);
    intermediate_offset_one_i <= 24'h0003E8;
    wr(8'hAC, 4'hF, 32'h0000000D);
    repeat (2) @(posedge clk_i);
    check({7'h00, applied_offset_o}, 32'h000003E8);
    check({7'h00, intermediate_hz_o}, 32'h000B7598);
    wr(8'hAC, 4'hF, 32'h00000009);
    check({7'h00, applied_offset_o}, 32'h00000000);
    check({7'h00, intermediate_hz_o}, 32'h000B71B0);
    // Lowest legal offset at the low band lands on zero
    wr(8'hB4, 4'hF, 32'h00F79B90);
    wr(8'hAC, 4'hF, 32'h00000004);
    check({7'h00, intermediate_hz_o}, 32'h00000000);
    $display("test offset done");
  endtask

  // Unmapped place: acked, reads zero, write ignored
  task automatic t_unmapped();
    wr(8'hC0, 4'hF, 32'h12345678);
    rd_chk(8'hC0, 32'h00000000);
    rd_chk(8'hA8, 32'h05F5E100);
    $display("test unmapped done");
  endtask

  // Mid-run reset drops written values and a half-built word
  task automatic t_mid_reset();
    wr(8'hA8, 4'h1, 32'h00000011);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    check({2'b00, carrier_hz_value_o}, 32'h36FC3BA0);
    check({28'h0, choice_o, ofs_en_o, shift_o, band_o}, 32'h00000000);
    check({7'h00, intermediate_hz_o}, 32'h00086470);
    check({8'h00, ofs_zero_o}, 32'h00000000);
    rd_chk(8'hB8, 32'h00000001);
    $display("test mid reset done");
  endtask

  // Hang guard, ceiling well above the expected run
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      err_count++;
      final_report();
    end
  end

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_carrier_bytes();
    t_carrier_range();
    t_ctrl_bits();
    t_offset();
    t_unmapped();
    t_mid_reset();
    repeat (2) @(posedge clk_i);
    final_report();
  end
endmodule

`default_nettype wire
